// File: include/reset_seq_pkg.sv
package reset_seq_pkg;

   // Register byte offsets.
   localparam logic [7:0] HARDWARE_CONFIG_OFS   = 8'h00;
   localparam logic [7:0] POWER_MGMT_CONTROL_OFS = 8'h04;
   localparam logic [7:0] WAKE_TEST_OFS         = 8'h08;
   localparam logic [7:0] PHY_BASIC_CTRL_OFS    = 8'h0C;
   localparam logic [7:0] PHY_BASIC_STATUS_OFS  = 8'h10;
   localparam logic [7:0] EEPROM_COMMAND_OFS    = 8'h14;

   // Field positions.
   localparam int SOFT_RESET_BIT      = 0;
   localparam int PRESERVED_LSB       = 8;
   localparam int GENERAL_CFG_LSB     = 16;
   localparam int READY_BIT           = 0;
   localparam int PMT_PHY_RESET_BIT   = 10;
   localparam int PM_MODE_LSB         = 12;
   localparam int PHY_CTRL_RESET_BIT  = 15;
   localparam int LINK_STATUS_BIT     = 2;
   localparam int EEPROM_FOUND_BIT    = 8;
   localparam int EEPROM_BUSY_BIT     = 31;

   // Power modes.
   localparam logic [1:0] PM_NORMAL = 2'h0;
   localparam logic [1:0] PM_SLEEP1 = 2'h1;
   localparam logic [1:0] PM_SLEEP2 = 2'h2;

   // Value returned by the wake test register; arbitrary pattern.
   localparam logic [31:0] WAKE_TEST_PATTERN = 32'h5A5AC3C3;

   // Timing.
   localparam int CLK_HZ         = 25_000_000;
   localparam int POR_HOLD_MS    = 22;
   localparam int WAKE_MAX_MS    = 2;
   localparam int SOFT_RESET_US  = 2;
   localparam int PHY_RESET_US   = 100;
   localparam int POR_HOLD_CYC   = (POR_HOLD_MS * (CLK_HZ / 1000) * 1 + 0);
   localparam int WAKE_MAX_CYC   = WAKE_MAX_MS * (CLK_HZ / 1000);
   // Divide first, since microseconds times the clock rate overflows a 32-bit int.
   localparam int SOFT_RESET_CYC = SOFT_RESET_US * (CLK_HZ / 1_000_000);
   localparam int PHY_RESET_CYC  = PHY_RESET_US * (CLK_HZ / 1_000_000);
   localparam int HW_RESET_CYC   = 16;
   localparam int EEPROM_PROBE_CYC = 8;

   // Sequencer states, Gray coded along power-on, probe, run, sleep, wake.
   typedef enum logic [2:0] {
      S_POR   = 3'h0,
      S_PROBE = 3'h1,
      S_RUN   = 3'h3,
      S_SLEEP = 3'h2,
      S_WAKE  = 3'h6,
      S_HWRST = 3'h4,
      S_SOFT  = 3'h5
   } seq_state_t;

endpackage : reset_seq_pkg

// File: hw/sync_2ff.sv
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
   parameter int              WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             reset,
   // Asynchronous in, synchronous out
   input  wire logic [WIDTH-1:0] async_in,
   output      logic [WIDTH-1:0] sync_out
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_state_t;

   sync_state_t q;
   sync_state_t d;

   always_comb begin
      d.meta   = async_in;
      d.stable = q.meta;
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         q <= {RESET_VAL, RESET_VAL};
      end else begin
         q <= d;
      end
   end

   assign sync_out = q.stable;

endmodule : sync_2ff
`default_nettype wire

// File: hw/reset_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module reset_sequencer
   import reset_seq_pkg::*;
#(
   parameter int unsigned POR_CYC  = POR_HOLD_CYC,
   parameter int unsigned WAKE_CYC = WAKE_MAX_CYC
) (
   // Clock and power-on reset
   input  wire logic        clk_sys,
   input  wire logic        reset,
   // Avalon-MM slave
   input  wire logic [7:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output      logic [31:0] readdata,
   output      logic        waitrequest,
   // Pins and PHY status
   input  wire logic        external_reset_in_low,
   input  wire logic        eeprom_detect_in,
   input  wire logic        link_status_in,
   // Reset and status outputs
   output      logic        core_reset,
   output      logic        phy_reset,
   output      logic        eeprom_probe,
   output      logic        ready,
   output      logic [1:0]  pm_mode
);

   typedef struct packed {
      seq_state_t  state;
      logic [19:0] cnt;
      logic [11:0] phy_cnt;
      logic        phy_busy;
      logic        ready;
      logic [1:0]  pm_mode;
      logic [7:0]  cfg_keep;
      logic [7:0]  cfg_gen;
      logic [14:0] phy_ctrl;
      logic        ee_found;
      logic        core_rst;
      logic        phy_rst;
      logic        ee_probe;
      logic        waitrequest;
      logic [31:0] rdata;
   } state_t;

   localparam state_t RESET_STATE = '{
      state: S_POR, cnt: 20'h0, phy_cnt: 12'h0, phy_busy: 1'b0, ready: 1'b0,
      pm_mode: PM_NORMAL, cfg_keep: 8'h0, cfg_gen: 8'h0, phy_ctrl: 15'h0,
      ee_found: 1'b0, core_rst: 1'b1, phy_rst: 1'b1, ee_probe: 1'b0,
      waitrequest: 1'b1, rdata: 32'h0};

   state_t q;
   state_t d;
   logic   pin_n_s;
   logic   ee_s;
   logic   link_s;

   sync_2ff #(
      .WIDTH     (3),
      .RESET_VAL (3'h4)
   ) u_sync (
      .clk_sys  (clk_sys),
      .reset    (reset),
      .async_in ({external_reset_in_low, eeprom_detect_in, link_status_in}),
      .sync_out ({pin_n_s, ee_s, link_s})
   );

   function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge_be

   function automatic logic at_end(input logic [19:0] cnt, input int unsigned lim);
      return cnt == 20'(lim - 1);
   endfunction : at_end

   logic        acc;
   logic        wr_go;
   logic [31:0] rd_val;
   logic [31:0] wval;

   always_comb begin
      d      = q;
      acc    = (read | write) & q.waitrequest;
      wr_go  = write & ~q.waitrequest;
      rd_val = 32'h0;
      wval   = 32'h0;

      // Register read values.
      case (address)
         HARDWARE_CONFIG_OFS: begin
            rd_val[SOFT_RESET_BIT] = (q.state == S_SOFT);
            rd_val[PRESERVED_LSB +: 8]   = q.cfg_keep;
            rd_val[GENERAL_CFG_LSB +: 8] = q.cfg_gen;
         end
         POWER_MGMT_CONTROL_OFS: begin
            rd_val[READY_BIT]         = q.ready;
            rd_val[PMT_PHY_RESET_BIT] = q.phy_busy;
            rd_val[PM_MODE_LSB +: 2]  = q.pm_mode;
         end
         WAKE_TEST_OFS: begin
            rd_val = WAKE_TEST_PATTERN;
         end
         PHY_BASIC_CTRL_OFS: begin
            rd_val[14:0]               = q.phy_ctrl;
            rd_val[PHY_CTRL_RESET_BIT] = q.phy_busy;
         end
         PHY_BASIC_STATUS_OFS: begin
            rd_val[LINK_STATUS_BIT] = link_s;
         end
         EEPROM_COMMAND_OFS: begin
            rd_val[EEPROM_BUSY_BIT]  = q.ee_probe;
            rd_val[EEPROM_FOUND_BIT] = q.ee_found;
         end
         default: begin
            rd_val = 32'h0;
         end
      endcase

      // One wait cycle per access; data is captured while waitrequest drops.
      d.waitrequest = 1'b1;
      if (acc) begin
         d.waitrequest = 1'b0;
         d.rdata       = read ? rd_val : 32'h0;
      end

      case (q.state)
         S_POR: begin
            d.cnt = q.cnt + 20'h1;
            if (at_end(q.cnt, POR_CYC)) begin
               d.state    = S_PROBE;
               d.cnt      = 20'h0;
               d.ready    = 1'b1;
               d.core_rst = 1'b0;
               d.phy_rst  = 1'b0;
               d.ee_probe = 1'b1;
            end
         end
         S_HWRST: begin
            d.cnt = q.cnt + 20'h1;
            if (at_end(q.cnt, HW_RESET_CYC)) begin
               d.state    = S_PROBE;
               d.cnt      = 20'h0;
               d.ready    = 1'b1;
               d.core_rst = 1'b0;
               d.phy_rst  = 1'b0;
               d.ee_probe = 1'b1;
            end
         end
         S_SOFT: begin
            d.cnt = q.cnt + 20'h1;
            if (at_end(q.cnt, SOFT_RESET_CYC)) begin
               d.state    = S_PROBE;
               d.cnt      = 20'h0;
               d.core_rst = 1'b0;
               d.ee_probe = 1'b1;
            end
         end
         S_PROBE: begin
            d.cnt = q.cnt + 20'h1;
            if (at_end(q.cnt, EEPROM_PROBE_CYC)) begin
               d.state    = S_RUN;
               d.cnt      = 20'h0;
               d.ee_found = ee_s;
               d.ee_probe = 1'b0;
            end
         end
         S_WAKE: begin
            d.cnt = q.cnt + 20'h1;
            if (at_end(q.cnt, WAKE_CYC)) begin
               d.state = S_RUN;
               d.cnt   = 20'h0;
               d.ready = 1'b1;
            end
         end
         S_RUN, S_SLEEP: begin
            d.cnt = 20'h0;
         end
         default: begin
            d = RESET_STATE;
         end
      endcase

      if (q.phy_busy) begin
         d.phy_cnt = q.phy_cnt + 12'h1;
         if (q.phy_cnt == 12'(PHY_RESET_CYC - 1)) begin
            d.phy_busy = 1'b0;
            d.phy_rst  = 1'b0;
         end
      end

      // only the wake write acts while not ready
      if (wr_go) begin
         case (address)
            HARDWARE_CONFIG_OFS: begin
               if (q.ready && q.state == S_RUN) begin
                  wval       = merge_be(rd_val, writedata, byteenable);
                  d.cfg_keep = wval[PRESERVED_LSB +: 8];
                  d.cfg_gen  = wval[GENERAL_CFG_LSB +: 8];
                  if (wval[SOFT_RESET_BIT]) begin
                     d.state    = S_SOFT;
                     d.cnt      = 20'h0;
                     d.cfg_gen  = 8'h0;
                     d.core_rst = 1'b1;
                  end
               end
            end
            POWER_MGMT_CONTROL_OFS: begin
               if (q.ready && q.state == S_RUN) begin
                  wval = merge_be(rd_val, writedata, byteenable);
                  if (wval[PMT_PHY_RESET_BIT] && !q.phy_busy) begin
                     d.phy_busy = 1'b1;
                     d.phy_cnt  = 12'h0;
                     d.phy_rst  = 1'b1;
                     d.phy_ctrl = 15'h0;
                  end
                  if (wval[PM_MODE_LSB +: 2] == PM_SLEEP1 ||
                      wval[PM_MODE_LSB +: 2] == PM_SLEEP2) begin
                     d.pm_mode = wval[PM_MODE_LSB +: 2];
                     d.state   = S_SLEEP;
                     d.ready   = 1'b0;
                  end
               end
            end
            WAKE_TEST_OFS: begin
               if (q.state == S_SLEEP) begin
                  d.state   = S_WAKE;
                  d.cnt     = 20'h0;
                  d.pm_mode = PM_NORMAL;
               end
            end
            PHY_BASIC_CTRL_OFS: begin
               if (q.ready && q.state == S_RUN) begin
                  wval       = merge_be(rd_val, writedata, byteenable);
                  d.phy_ctrl = wval[14:0];
                  if (wval[PHY_CTRL_RESET_BIT] && !q.phy_busy) begin
                     d.phy_busy = 1'b1;
                     d.phy_cnt  = 12'h0;
                     d.phy_rst  = 1'b1;
                     d.phy_ctrl = 15'h0;
                  end
               end
            end
            default: begin
               wval = 32'h0;
            end
         endcase
      end

      if (!pin_n_s) begin
         d             = RESET_STATE;
         d.state       = S_HWRST;
         d.waitrequest = acc ? 1'b0 : 1'b1;
         d.rdata       = (acc && read) ? rd_val : q.rdata;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         q <= RESET_STATE;
      end else begin
         q <= d;
      end
   end

   assign readdata     = q.rdata;
   assign waitrequest  = q.waitrequest;
   assign core_reset   = q.core_rst;
   assign phy_reset    = q.phy_rst;
   assign eeprom_probe = q.ee_probe;
   assign ready        = q.ready;
   assign pm_mode      = q.pm_mode;

endmodule : reset_sequencer
`default_nettype wire

// File: tb/reset_seq_checker.sv
`timescale 1ns/1ps
`default_nettype none
module reset_seq_checker
   import reset_seq_pkg::*;
#(
   parameter int unsigned POR_CYC  = POR_HOLD_CYC,
   parameter int unsigned WAKE_CYC = WAKE_MAX_CYC
) (
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        reset,
   // Bus
   input wire logic [7:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] writedata,
   input wire logic [3:0]  byteenable,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   // Pins and status
   input wire logic        external_reset_in_low,
   input wire logic        eeprom_detect_in,
   input wire logic        link_status_in,
   input wire logic        core_reset,
   input wire logic        phy_reset,
   input wire logic        eeprom_probe,
   input wire logic        ready,
   input wire logic [1:0]  pm_mode
);
   logic [31:0] hold_q;
   logic [31:0] wake_q;
   logic        por_q;
   // The power-on flag separates the first hold from later pin or soft holds.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         hold_q <= '0;
         wake_q <= '0;
         por_q  <= 1'b1;
      end else begin
         hold_q <= core_reset ? hold_q + 32'h1 : '0;
         wake_q <= (!ready && !core_reset && pm_mode == PM_NORMAL) ? wake_q + 32'h1 : '0;
         if (!core_reset) por_q <= 1'b0;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   por_hold_len_a: assert property (
      $fell(core_reset) && por_q |-> hold_q >= POR_CYC - 1 && hold_q <= POR_CYC + 3)
      else $error("power-on hold length wrong");
   ready_in_reset_a: assert property (
      core_reset && phy_reset && $past(core_reset) |-> !ready)
      else $error("ready high during chip reset");
   pin_forces_reset_a: assert property (
      !external_reset_in_low [*6] |-> core_reset && phy_reset)
      else $error("low pin did not reset");
   wake_ready_bound_a: assert property (
      wake_q <= WAKE_CYC + 2)
      else $error("ready late after wake");
   probe_after_reset_a: assert property (
      $fell(core_reset) |-> ##[0:2] eeprom_probe)
      else $error("no probe after reset");
   probe_length_a: assert property (
      $rose(eeprom_probe) |-> eeprom_probe [*8] ##1 !eeprom_probe)
      else $error("probe length wrong");
   sleep_not_ready_a: assert property (
      pm_mode != PM_NORMAL |-> !ready)
      else $error("ready high while asleep");
   bus_answer_next_a: assert property (
      (read || write) && waitrequest |=> !waitrequest)
      else $error("bus answer late");
   bus_answer_pulse_a: assert property (
      !waitrequest |=> waitrequest)
      else $error("waitrequest low too long");
endmodule : reset_seq_checker
bind reset_sequencer reset_seq_checker #(.POR_CYC(POR_CYC), .WAKE_CYC(WAKE_CYC)) u_chk (
   .clk_sys(clk_sys), .reset(reset), .address(address), .read(read), .write(write),
   .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
   .waitrequest(waitrequest), .external_reset_in_low(external_reset_in_low),
   .eeprom_detect_in(eeprom_detect_in), .link_status_in(link_status_in),
   .core_reset(core_reset), .phy_reset(phy_reset), .eeprom_probe(eeprom_probe),
   .ready(ready), .pm_mode(pm_mode));
`default_nettype wire

// File: tb/host_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
   // Clock
   input  wire logic        clk_sys,
   // Bus master side
   output var  logic [7:0]  address,
   output var  logic        read,
   output var  logic        write,
   output var  logic [31:0] writedata,
   output var  logic [3:0]  byteenable,
   input  wire logic [31:0] readdata,
   input  wire logic        waitrequest
);
   initial begin
      address    = 8'h00;
      read       = 1'b0;
      write      = 1'b0;
      writedata  = 32'h0;
      byteenable = 4'hF;
   end
   // Released lines show the inverse so stale values are never mistaken for data.
   task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
      address <= a;
      read    <= 1'b1;
      do @(posedge clk_sys); while (waitrequest !== 1'b0);
      d = readdata;
      read    <= 1'b0;
      address <= ~a;
      @(posedge clk_sys);
   endtask : bus_read
   task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
      address   <= a;
      writedata <= d;
      write     <= 1'b1;
      do @(posedge clk_sys); while (waitrequest !== 1'b0);
      write     <= 1'b0;
      address   <= ~a;
      writedata <= ~d;
      @(posedge clk_sys);
   endtask : bus_write
   task automatic poll_bit(input logic [7:0] a, input int b, input logic v);
      logic [31:0] d;
      do bus_read(a, d); while (d[b] !== v);
   endtask : poll_bit
endmodule : host_cpu_model
`default_nettype wire

// File: tb/ethernet_ctrl_reset_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
module ethernet_ctrl_reset_sequencer_test;
   import reset_seq_pkg::*;
   localparam int POR_T = 20;
   localparam int WAKE_T = 10;
   localparam int LIMIT = 20000;
   logic        clk_sys = 1'b0, reset = 1'b1, pin_low = 1'b0;
   logic        eeprom_present = 1'b1, link_up = 1'b0;
   logic [7:0]  address;
   logic        read, write, waitrequest, core_reset, phy_reset, eeprom_probe, ready;
   logic [31:0] writedata, readdata, rd;
   logic [3:0]  byteenable;
   logic [1:0]  pm_mode;
   int          error_cnt = 0, tests_run = 0, cyc = 0, t0;
   wire logic   external_reset_in_low = pin_low ? 1'b0 : 1'b1;
   always #20 clk_sys = ~clk_sys;
   reset_sequencer #(.POR_CYC(POR_T), .WAKE_CYC(WAKE_T)) u_reset_sequencer (
      .clk_sys(clk_sys), .reset(reset), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .external_reset_in_low(external_reset_in_low),
      .eeprom_detect_in(eeprom_present), .link_status_in(link_up),
      .core_reset(core_reset), .phy_reset(phy_reset), .eeprom_probe(eeprom_probe),
      .ready(ready), .pm_mode(pm_mode));
   host_cpu_model u_host_cpu_model (
      .clk_sys(clk_sys), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest));
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         error_cnt++;
         complete_run();
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      u_host_cpu_model.bus_read(a, rd);
      check(rd & m, e);
   endtask : rd_chk
   task automatic span_chk(input int lo, input int hi);
      check(32'((cyc - t0) >= lo && (cyc - t0) <= hi), 32'h1);
   endtask : span_chk
   initial begin
      repeat (3) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      t0 = cyc;
      rd_chk(POWER_MGMT_CONTROL_OFS, 32'h1, 32'h0);
      u_host_cpu_model.poll_bit(POWER_MGMT_CONTROL_OFS, READY_BIT, 1'b1);
      span_chk(POR_T - 1, POR_T + 8);
      check(32'(core_reset), 32'h0);
      u_host_cpu_model.poll_bit(EEPROM_COMMAND_OFS, EEPROM_BUSY_BIT, 1'b0);
      rd_chk(EEPROM_COMMAND_OFS, 32'h100, 32'h100);
      rd_chk(WAKE_TEST_OFS, 32'hFFFFFFFF, WAKE_TEST_PATTERN);
      rd_chk(8'h3C, 32'hFFFFFFFF, 32'h0);
      $display("test power_on finished");
      u_host_cpu_model.bus_write(HARDWARE_CONFIG_OFS, 32'h00ABCD00);
      rd_chk(HARDWARE_CONFIG_OFS, 32'hFFFFFFFF, 32'h00ABCD00);
      u_host_cpu_model.bus_write(HARDWARE_CONFIG_OFS, 32'h00ABCD01);
      t0 = cyc;
      rd_chk(HARDWARE_CONFIG_OFS, 32'h1, 32'h1);
      rd_chk(POWER_MGMT_CONTROL_OFS, 32'h1, 32'h1);
      u_host_cpu_model.poll_bit(HARDWARE_CONFIG_OFS, SOFT_RESET_BIT, 1'b0);
      span_chk(SOFT_RESET_CYC - 2, SOFT_RESET_CYC + 6);
      rd_chk(HARDWARE_CONFIG_OFS, 32'hFFFFFFFF, 32'h0000CD00);
      u_host_cpu_model.poll_bit(EEPROM_COMMAND_OFS, EEPROM_BUSY_BIT, 1'b0);
      $display("test soft_reset finished");
      u_host_cpu_model.bus_write(POWER_MGMT_CONTROL_OFS, 32'h00000400);
      t0 = cyc;
      check(32'(phy_reset), 32'h1);
      rd_chk(POWER_MGMT_CONTROL_OFS, 32'h401, 32'h401);
      u_host_cpu_model.poll_bit(POWER_MGMT_CONTROL_OFS, PMT_PHY_RESET_BIT, 1'b0);
      span_chk(PHY_RESET_CYC - 3, PHY_RESET_CYC + 6);
      check(32'({phy_reset, core_reset}), 32'h0);
      u_host_cpu_model.bus_write(PHY_BASIC_CTRL_OFS, 32'h00001234);
      rd_chk(PHY_BASIC_CTRL_OFS, 32'hFFFF, 32'h1234);
      u_host_cpu_model.bus_write(PHY_BASIC_CTRL_OFS, 32'h00009234);
      rd_chk(PHY_BASIC_CTRL_OFS, 32'h8000, 32'h8000);
      u_host_cpu_model.poll_bit(PHY_BASIC_CTRL_OFS, PHY_CTRL_RESET_BIT, 1'b0);
      rd_chk(PHY_BASIC_CTRL_OFS, 32'hFFFF, 32'h0);
      link_up <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rd_chk(PHY_BASIC_STATUS_OFS, 32'h4, 32'h4);
      $display("test phy_reset finished");
      for (int m = 1; m <= 2; m++) begin
         u_host_cpu_model.bus_write(POWER_MGMT_CONTROL_OFS, 32'(m) << PM_MODE_LSB);
         rd_chk(POWER_MGMT_CONTROL_OFS, 32'h3001, 32'(m) << PM_MODE_LSB);
         // only the waking write while asleep
         u_host_cpu_model.bus_write(WAKE_TEST_OFS, 32'h0);
         t0 = cyc;
         u_host_cpu_model.poll_bit(POWER_MGMT_CONTROL_OFS, READY_BIT, 1'b1);
         span_chk(0, WAKE_T + 6);
         rd_chk(POWER_MGMT_CONTROL_OFS, 32'h3000, 32'h0);
      end
      $display("test sleep_wake finished");
      u_host_cpu_model.bus_write(HARDWARE_CONFIG_OFS, 32'h0000CD00);
      eeprom_present <= 1'b0;
      pin_low        <= 1'b1;
      repeat (8) @(posedge clk_sys);
      rd_chk(POWER_MGMT_CONTROL_OFS, 32'h1, 32'h0);
      check(32'({core_reset, phy_reset}), 32'h3);
      pin_low <= 1'b0;
      t0 = cyc;
      u_host_cpu_model.poll_bit(POWER_MGMT_CONTROL_OFS, READY_BIT, 1'b1);
      span_chk(HW_RESET_CYC, HW_RESET_CYC + 10);
      rd_chk(HARDWARE_CONFIG_OFS, 32'hFFFFFFFF, 32'h0);
      u_host_cpu_model.poll_bit(EEPROM_COMMAND_OFS, EEPROM_BUSY_BIT, 1'b0);
      rd_chk(EEPROM_COMMAND_OFS, 32'h100, 32'h0);
      $display("test pin_reset finished");
      complete_run();
   end
endmodule : ethernet_ctrl_reset_sequencer_test
`default_nettype wire
